// ==== logic/flash_cfg_pkg.sv ====
// constants, field layouts and carrier types of the flash config/status bank
package flash_cfg_pkg;

    localparam logic [7:0] OFS_IO = 8'h00;
    localparam logic [7:0] OFS_WAIT = 8'h01;
    localparam logic [7:0] OFS_DRV = 8'h03;
    localparam logic [7:0] OFS_ADDRW = 8'h05;
    localparam logic [7:0] OFS_XIP = 8'h06;
    localparam logic [7:0] OFS_WRAP = 8'h07;
    localparam logic [7:0] OFS_CTRL = 8'h0b;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_FCA0 = 8'h0d;
    localparam logic [7:0] OFS_FCA1 = 8'h0e;
    localparam logic [7:0] OFS_FCA2 = 8'h0f;
    localparam logic [7:0] OFS_FCA3 = 8'h10;
    localparam logic [7:0] OFS_BANK = 8'h11;

    localparam logic [7:0] BYTE_ERASED = 8'hff;
    localparam logic [7:0] WAIT_RESET = 8'h1f;
    localparam logic [7:0] BANK_IDLE = 8'h00;
    localparam logic [3:0] FCA_LOW_NIBBLE = 4'h0;

    localparam logic [7:0] WRAP_CONT = 8'hff;
    localparam logic [7:0] WRAP_16 = 8'hfc;
    localparam logic [7:0] XIP_OFF = 8'hff;
    localparam logic [7:0] XIP_OCTAL_IO = 8'hfe;
    localparam logic [7:0] XIP_OCTAL_OUT = 8'hfd;
    localparam logic [7:0] XIP_FAST = 8'hf8;
    localparam logic [7:0] ADDR_3 = 8'hff;
    localparam logic [7:0] ADDR_4 = 8'hfe;
    localparam logic [7:0] DRV_50 = 8'hff;
    localparam logic [7:0] DRV_18 = 8'hfc;
    localparam logic [7:0] WAIT_ZERO = 8'h00;
    localparam logic [7:0] WAIT_MAX = 8'h1e;
    localparam logic [7:0] WAIT_DEFAULT = 8'h1f;
    localparam logic [7:0] IO_EXT = 8'hff;
    localparam logic [7:0] IO_EXT_NOSTROBE = 8'hdf;
    localparam logic [7:0] IO_ODDR = 8'he7;
    localparam logic [7:0] IO_ODDR_NOSTROBE = 8'hc7;

    localparam int CTRL_ECC_TYPE_BIT = 2;
    localparam logic [3:0] COUNT_MAX = 4'hf;
    localparam logic [1:0] SETTLE_CYCLES = 2'h3;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'b001,
        ST_LOAD = 3'b010,
        ST_RUN = 3'b100
    } state_e;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] wrap;
        logic [7:0] xip;
        logic [7:0] addrw;
        logic [7:0] drv;
        logic [7:0] wait_sel;
        logic [7:0] io;
    } cfg_set_s;

    localparam cfg_set_s CFG_RESET = '{ctrl: BYTE_ERASED, wrap: WRAP_CONT,
        xip: XIP_OFF, addrw: ADDR_3, drv: DRV_50, wait_sel: WAIT_RESET,
        io: IO_EXT};

    typedef struct packed {
        logic valid;
        logic write;
        logic nonvolatile;
        logic [7:0] addr;
        logic [7:0] wdata;
    } cmd_s;

    typedef struct packed {
        logic corr;
        logic dbl;
        logic parity;
        logic crc;
        logic incr;
        logic [27:0] chunk;
    } ecc_evt_s;

    typedef struct packed {
        logic incr;
        logic [3:0] count;
        logic dbl;
        logic par;
        logic crc;
        logic [27:0] fca;
    } ecc_stat_s;

endpackage : flash_cfg_pkg

// ==== logic/sync2.sv ====
// two flip-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_s;

    sync_s r;
    sync_s next_r;

    if (WIDTH < 1) begin : g_bad_width
        $error("sync2 needs a width of at least one");
    end

    // the first stage feeds only the second stage
    always_comb begin
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule : sync2
`default_nettype wire

// ==== logic/ecc_status_capture.sv ====
// sticky ecc flags, correction counter and failing chunk address
`timescale 1ns/10ps
`default_nettype none
module ecc_status_capture (
    input wire logic mclk,
    input wire logic rst_b,
    input wire flash_cfg_pkg::ecc_evt_s evt,
    input wire logic type_sel,
    output var flash_cfg_pkg::ecc_stat_s stat
);
    flash_cfg_pkg::ecc_stat_s r;
    flash_cfg_pkg::ecc_stat_s next_r;

    // flags have no host clear; only reset drops them
    always_comb begin
        next_r = r;
        if (evt.incr) begin
            next_r.incr = 1'b1;
        end
        if (evt.corr && (r.count != flash_cfg_pkg::COUNT_MAX)) begin
            next_r.count = r.count + 4'h1;
        end
        if (evt.dbl) begin
            next_r.dbl = 1'b1;
        end
        if (evt.parity) begin
            next_r.par = 1'b1;
        end
        if (evt.crc) begin
            next_r.crc = 1'b1;
        end
        // one means double-bit detection is captured
        if (type_sel ? evt.dbl : evt.corr) begin
            next_r.fca = evt.chunk;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign stat = r;
endmodule : ecc_status_capture
`default_nettype wire

// ==== logic/flash_config_status_regs.sv ====
// volatile and nonvolatile config bytes plus ecc/bank status read-back
`timescale 1ns/10ps
`default_nettype none
module flash_config_status_regs #(
    parameter int ADDR_WIDTH = 32
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic link_clk,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic cmd_nonvolatile,
    input wire logic [ADDR_WIDTH-1:0] cmd_addr,
    input wire logic [7:0] cmd_wdata,
    input wire logic octal_ddr_boot_option,
    input wire flash_cfg_pkg::ecc_evt_s ecc_evt,
    input wire logic bank_busy,
    input wire logic [1:0] bank_id,
    output logic [7:0] rd_data,
    output logic rd_valid,
    output logic reserved_write_flag,
    output logic wel_clear,
    output var flash_cfg_pkg::cfg_set_s active_cfg,
    output logic [4:0] fast_read_wait,
    output logic addr_four_byte,
    output logic octal_ddr,
    output logic strobe_enable,
    output logic ecc_error_type_select,
    output logic cfg_ready
);
    typedef struct packed {
        flash_cfg_pkg::state_e state;
        logic [1:0] settle;
        logic boot;
        logic lclk_prev;
        flash_cfg_pkg::cfg_set_s vol;
        flash_cfg_pkg::cfg_set_s nv;
        flash_cfg_pkg::cfg_set_s act;
        logic [7:0] bank;
        logic [7:0] rd_data;
        logic rd_valid;
        logic rsv;
        logic wel_clr;
        logic [4:0] wait_cyc;
        logic four;
        logic ddr;
        logic strobe;
        logic ecc_type;
        logic ready;
    } top_s;

    top_s r;
    top_s next_r;
    logic lclk_s;
    logic boot_s;
    flash_cfg_pkg::cmd_s cmd_s;
    flash_cfg_pkg::cmd_s cmd_raw;
    flash_cfg_pkg::ecc_stat_s stat;
    logic lclk_rise;
    // link clock, strap and command share one synchroniser
    localparam int SYNC_WIDTH = $bits(flash_cfg_pkg::cmd_s) + 2;

    // the register select needs at least the low address byte
    if (ADDR_WIDTH < 8) begin : g_bad_addr_width
        $error("command address must be at least one byte wide");
    end

    // upper address bytes are not decoded at all
    always_comb begin
        cmd_raw.valid = cmd_valid;
        cmd_raw.write = cmd_write;
        cmd_raw.nonvolatile = cmd_nonvolatile;
        cmd_raw.addr = cmd_addr[7:0];
        cmd_raw.wdata = cmd_wdata;
    end

    // command fields ride the same two-stage path as the link clock,
    // so they line up with its sampled edge if held around it
    sync2 #(
        .WIDTH(SYNC_WIDTH)
    ) u_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .d({link_clk, octal_ddr_boot_option, cmd_raw}),
        .q({lclk_s, boot_s, cmd_s})
    );

    // status capture runs in every state; only reset clears it
    ecc_status_capture u_ecc (
        .mclk(mclk),
        .rst_b(rst_b),
        .evt(ecc_evt),
        .type_sel(r.ecc_type),
        .stat(stat)
    );

    // one tick per link rise; the link period must span two ticks
    assign lclk_rise = lclk_s && !r.lclk_prev;

    // 0bh carries the ecc control bits and takes any value
    function automatic logic is_cfg_addr(input logic [7:0] a);
        is_cfg_addr = (a == flash_cfg_pkg::OFS_IO)
            || (a == flash_cfg_pkg::OFS_WAIT)
            || (a == flash_cfg_pkg::OFS_DRV)
            || (a == flash_cfg_pkg::OFS_ADDRW)
            || (a == flash_cfg_pkg::OFS_XIP)
            || (a == flash_cfg_pkg::OFS_WRAP)
            || (a == flash_cfg_pkg::OFS_CTRL);
    endfunction : is_cfg_addr

    // volatile writes to these bytes are dropped without a flag
    function automatic logic is_status_addr(input logic [7:0] a);
        is_status_addr = (a >= flash_cfg_pkg::OFS_FLAGS)
            && (a <= flash_cfg_pkg::OFS_BANK);
    endfunction : is_status_addr

    function automatic logic [7:0] get_byte(
        input flash_cfg_pkg::cfg_set_s s,
        input logic [7:0] a
    );
        if (a == flash_cfg_pkg::OFS_IO) begin
            get_byte = s.io;
        end else if (a == flash_cfg_pkg::OFS_WAIT) begin
            get_byte = s.wait_sel;
        end else if (a == flash_cfg_pkg::OFS_DRV) begin
            get_byte = s.drv;
        end else if (a == flash_cfg_pkg::OFS_ADDRW) begin
            get_byte = s.addrw;
        end else if (a == flash_cfg_pkg::OFS_XIP) begin
            get_byte = s.xip;
        end else if (a == flash_cfg_pkg::OFS_WRAP) begin
            get_byte = s.wrap;
        end else if (a == flash_cfg_pkg::OFS_CTRL) begin
            get_byte = s.ctrl;
        end else begin
            get_byte = flash_cfg_pkg::BYTE_ERASED;
        end
    endfunction : get_byte

    function automatic flash_cfg_pkg::cfg_set_s put_byte(
        input flash_cfg_pkg::cfg_set_s s,
        input logic [7:0] a,
        input logic [7:0] d
    );
        put_byte = s;
        if (a == flash_cfg_pkg::OFS_IO) begin
            put_byte.io = d;
        end else if (a == flash_cfg_pkg::OFS_WAIT) begin
            put_byte.wait_sel = d;
        end else if (a == flash_cfg_pkg::OFS_DRV) begin
            put_byte.drv = d;
        end else if (a == flash_cfg_pkg::OFS_ADDRW) begin
            put_byte.addrw = d;
        end else if (a == flash_cfg_pkg::OFS_XIP) begin
            put_byte.xip = d;
        end else if (a == flash_cfg_pkg::OFS_WRAP) begin
            put_byte.wrap = d;
        end else if (a == flash_cfg_pkg::OFS_CTRL) begin
            put_byte.ctrl = d;
        end
    endfunction : put_byte

    // accepted settings per byte; anything else is a reserved setting
    function automatic logic is_legal(
        input logic [7:0] a,
        input logic [7:0] d,
        input logic nv,
        input logic boot
    );
        if (a == flash_cfg_pkg::OFS_IO) begin
            if (nv && boot) begin
                // such parts only boot octal ddr with strobe
                is_legal = (d == flash_cfg_pkg::IO_EXT)
                    || (d == flash_cfg_pkg::IO_ODDR);
            end else begin
                is_legal = (d == flash_cfg_pkg::IO_EXT)
                    || (d == flash_cfg_pkg::IO_EXT_NOSTROBE)
                    || (d == flash_cfg_pkg::IO_ODDR)
                    || (d == flash_cfg_pkg::IO_ODDR_NOSTROBE);
            end
        end else if (a == flash_cfg_pkg::OFS_WAIT) begin
            is_legal = (d <= flash_cfg_pkg::WAIT_DEFAULT);
        end else if (a == flash_cfg_pkg::OFS_DRV) begin
            is_legal = (d >= flash_cfg_pkg::DRV_18);
        end else if (a == flash_cfg_pkg::OFS_ADDRW) begin
            is_legal = (d == flash_cfg_pkg::ADDR_3)
                || (d == flash_cfg_pkg::ADDR_4);
        end else if (a == flash_cfg_pkg::OFS_XIP) begin
            // the volatile copy knows only on and off
            is_legal = (d == flash_cfg_pkg::XIP_OFF)
                || (d == flash_cfg_pkg::XIP_OCTAL_IO)
                || (nv && (d == flash_cfg_pkg::XIP_OCTAL_OUT))
                || (nv && (d == flash_cfg_pkg::XIP_FAST));
        end else if (a == flash_cfg_pkg::OFS_WRAP) begin
            is_legal = (d >= flash_cfg_pkg::WRAP_16);
        end else if (a == flash_cfg_pkg::OFS_CTRL) begin
            is_legal = 1'b1;
        end else begin
            is_legal = 1'b0;
        end
    endfunction : is_legal

    // the chunk is kept from address bit 4 up; 0dh pads with zeros
    function automatic logic [7:0] status_byte(
        input flash_cfg_pkg::ecc_stat_s s,
        input logic [7:0] bank,
        input logic [7:0] a
    );
        if (a == flash_cfg_pkg::OFS_FLAGS) begin
            status_byte = {s.incr, s.count, s.dbl, s.par, s.crc};
        end else if (a == flash_cfg_pkg::OFS_FCA0) begin
            status_byte = {s.fca[3:0], flash_cfg_pkg::FCA_LOW_NIBBLE};
        end else if (a == flash_cfg_pkg::OFS_FCA1) begin
            status_byte = s.fca[11:4];
        end else if (a == flash_cfg_pkg::OFS_FCA2) begin
            status_byte = s.fca[19:12];
        end else if (a == flash_cfg_pkg::OFS_FCA3) begin
            status_byte = s.fca[27:20];
        end else if (a == flash_cfg_pkg::OFS_BANK) begin
            status_byte = bank;
        end else begin
            status_byte = flash_cfg_pkg::BYTE_ERASED;
        end
    endfunction : status_byte

    always_comb begin
        next_r = r;
        // pulses last one cycle unless set again below
        next_r.rd_valid = 1'b0;
        next_r.rsv = 1'b0;
        next_r.wel_clr = 1'b0;
        next_r.lclk_prev = lclk_s;
        // a busy bank reads as 1xx, idle as 000
        next_r.bank = bank_busy ? {5'h00, 1'b1, bank_id}
                                : flash_cfg_pkg::BANK_IDLE;
        // commands are ignored until the working copy is loaded
        case (r.state)
            flash_cfg_pkg::ST_SETTLE: begin
                // let the strap clear the synchroniser first
                if (r.settle == flash_cfg_pkg::SETTLE_CYCLES) begin
                    next_r.state = flash_cfg_pkg::ST_LOAD;
                end else begin
                    next_r.settle = r.settle + 2'h1;
                end
            end
            flash_cfg_pkg::ST_LOAD: begin
                // strap is caught once and held until the next reset
                next_r.boot = boot_s;
                next_r.act = r.nv;
                if (boot_s) begin
                    next_r.act.io = flash_cfg_pkg::IO_ODDR;
                end
                next_r.state = flash_cfg_pkg::ST_RUN;
            end
            flash_cfg_pkg::ST_RUN: begin
                if (lclk_rise && cmd_s.valid) begin
                    if (!cmd_s.write) begin
                        next_r.rd_valid = 1'b1;
                        if (is_cfg_addr(cmd_s.addr)) begin
                            next_r.rd_data = get_byte(
                                cmd_s.nonvolatile ? r.nv : r.vol,
                                cmd_s.addr);
                        end else if (!cmd_s.nonvolatile) begin
                            next_r.rd_data = status_byte(stat, r.bank,
                                cmd_s.addr);
                        end else begin
                            // the nonvolatile set has no status bytes
                            next_r.rd_data = flash_cfg_pkg::BYTE_ERASED;
                        end
                    end else if (is_legal(cmd_s.addr, cmd_s.wdata,
                                          cmd_s.nonvolatile, r.boot)) begin
                        if (cmd_s.nonvolatile) begin
                            // never reaches the working copy; reset reloads the defaults
                            next_r.nv = put_byte(r.nv, cmd_s.addr,
                                cmd_s.wdata);
                        end else begin
                            next_r.vol = put_byte(r.vol, cmd_s.addr,
                                cmd_s.wdata);
                            next_r.act = put_byte(r.act, cmd_s.addr,
                                cmd_s.wdata);
                        end
                    end else if (cmd_s.nonvolatile
                                 || !is_status_addr(cmd_s.addr)) begin
                        next_r.rsv = 1'b1;
                        next_r.wel_clr = 1'b1;
                    end
                    // volatile status writes fall through untouched
                end
            end
            default: begin
                next_r.state = flash_cfg_pkg::ST_SETTLE;
            end
        endcase
        // levels decode the next working copy, so they never lag it
        // 00h behaves as the command default 1fh
        if (next_r.act.wait_sel == flash_cfg_pkg::WAIT_ZERO) begin
            next_r.wait_cyc = flash_cfg_pkg::WAIT_DEFAULT[4:0];
        end else begin
            next_r.wait_cyc = next_r.act.wait_sel[4:0];
        end
        next_r.four = (next_r.act.addrw == flash_cfg_pkg::ADDR_4);
        next_r.ddr = (next_r.act.io == flash_cfg_pkg::IO_ODDR)
            || (next_r.act.io == flash_cfg_pkg::IO_ODDR_NOSTROBE);
        next_r.strobe = (next_r.act.io == flash_cfg_pkg::IO_EXT)
            || (next_r.act.io == flash_cfg_pkg::IO_ODDR);
        next_r.ecc_type =
            next_r.act.ctrl[flash_cfg_pkg::CTRL_ECC_TYPE_BIT];
        next_r.ready = (next_r.state == flash_cfg_pkg::ST_RUN);
    end

    // reset loads constants only; load fills the working copy
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            r <= '0;
            r.state <= flash_cfg_pkg::ST_SETTLE;
            r.vol <= flash_cfg_pkg::CFG_RESET;
            r.nv <= flash_cfg_pkg::CFG_RESET;
            r.act <= flash_cfg_pkg::CFG_RESET;
            r.wait_cyc <= flash_cfg_pkg::WAIT_DEFAULT[4:0];
            r.strobe <= 1'b1;
            r.ecc_type <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // every output is a register bit with no logic behind it
    assign rd_data = r.rd_data;
    assign rd_valid = r.rd_valid;
    assign reserved_write_flag = r.rsv;
    assign wel_clear = r.wel_clr;
    assign active_cfg = r.act;
    assign fast_read_wait = r.wait_cyc;
    assign addr_four_byte = r.four;
    assign octal_ddr = r.ddr;
    assign strobe_enable = r.strobe;
    assign ecc_error_type_select = r.ecc_type;
    assign cfg_ready = r.ready;
endmodule : flash_config_status_regs
`default_nettype wire

// ==== bench/flash_regs_chk_sva.sv ====
// assertion checker for the config/status register bank
`timescale 1ns/10ps
`default_nettype none
module flash_regs_chk (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic rd_valid,
    input wire logic reserved_write_flag,
    input wire logic wel_clear,
    input wire flash_cfg_pkg::cfg_set_s active_cfg,
    input wire logic [4:0] fast_read_wait,
    input wire logic addr_four_byte,
    input wire logic octal_ddr,
    input wire logic strobe_enable,
    input wire logic ecc_error_type_select,
    input wire logic cfg_ready
);
    logic [2:0] since_rst;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            since_rst <= 3'h0;
        end else if (since_rst != 3'h7) begin
            since_rst <= since_rst + 3'h1;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // decoded outputs register with the config in the same cycle; checks still wait for stability
    chk_wel_pair: assert property (reserved_write_flag == wel_clear)
        else $error("flag and latch clear apart");
    chk_refuse_hold: assert property (reserved_write_flag |->
        $stable(active_cfg)) else $error("refused write changed config");
    chk_addr_map: assert property ($stable(active_cfg) |->
        addr_four_byte == (active_cfg.addrw == 8'hfe))
        else $error("address width decode wrong");
    chk_wait_map: assert property ($stable(active_cfg) |->
        fast_read_wait == ((active_cfg.wait_sel == 8'h00) ? 5'h1f :
        active_cfg.wait_sel[4:0])) else $error("wait decode wrong");
    chk_io_map: assert property ($stable(active_cfg) |->
        octal_ddr == (active_cfg.io inside {8'he7, 8'hc7}) &&
        strobe_enable == (active_cfg.io inside {8'hff, 8'he7}))
        else $error("io mode decode wrong");
    chk_type_map: assert property ($stable(active_cfg) |->
        ecc_error_type_select == active_cfg.ctrl[2])
        else $error("error type select wrong");
    chk_load_late: assert property (since_rst < 3'h4 |-> !cfg_ready)
        else $error("config ready too early");
    chk_load_done: assert property (since_rst == 3'h7 |-> cfg_ready)
        else $error("config never loaded");
    chk_no_early: assert property (!cfg_ready |->
        !rd_valid && !reserved_write_flag) else $error("answer before load");
    cover property (rd_valid);
    cover property (reserved_write_flag);
    cover property ($rose(addr_four_byte));
endmodule : flash_regs_chk
bind flash_config_status_regs flash_regs_chk chk_u (.mclk, .rst_b,
    .rd_valid, .reserved_write_flag, .wel_clear, .active_cfg,
    .fast_read_wait, .addr_four_byte, .octal_ddr, .strobe_enable,
    .ecc_error_type_select, .cfg_ready);
`default_nettype wire

// ==== bench/xspi_host_model.sv ====
// host side model: issues one register command per link clock rise
`timescale 1ns/10ps
`default_nettype none
module xspi_host_model (
    input wire logic mclk,
    input wire logic [7:0] rd_data,
    input wire logic rd_valid,
    input wire logic reserved_write_flag,
    input wire logic wel_clear,
    output var logic link_clk,
    output var logic cmd_valid,
    output var logic cmd_write,
    output var logic cmd_nonvolatile,
    output var logic [31:0] cmd_addr,
    output var logic [7:0] cmd_wdata
);
    logic got_rd, got_flag, got_wel, valid_q, fresh;
    logic [7:0] got_data;
    // a new command clears what the one before left behind
    assign fresh = cmd_valid && !valid_q;
    initial begin
        {link_clk, cmd_valid, cmd_write, cmd_nonvolatile} = 4'h0;
        cmd_addr = 32'h0;
        cmd_wdata = 8'h0;
    end
    always @(posedge mclk) begin
        valid_q <= cmd_valid;
        if (rd_valid) got_data <= rd_data;
        got_rd <= (got_rd && !fresh) || rd_valid;
        got_flag <= (got_flag && !fresh) || reserved_write_flag;
        got_wel <= (got_wel && !fresh) || wel_clear;
    end
    // pins lead the rise by 3 cycles and trail it by 4; 160 ns period
    task xfer(input logic w, input logic nv, input logic [31:0] a,
        input logic [7:0] d);
        @(negedge mclk);
        {cmd_valid, cmd_write, cmd_nonvolatile} = {1'b1, w, nv};
        cmd_addr = a;
        cmd_wdata = d;
        repeat (3) @(negedge mclk);
        link_clk = 1'b1;
        repeat (4) @(negedge mclk);
        link_clk = 1'b0;
        cmd_valid = 1'b0;
        // released pins carry junk, not the last value
        cmd_addr = ~a;
        cmd_wdata = ~d;
    endtask : xfer
endmodule : xspi_host_model
`default_nettype wire

// ==== bench/flash_config_status_regs_tb.sv ====
// self-checking bench for the config/status register bank
`timescale 1ns/10ps
`default_nettype none
module flash_config_status_regs_tb;
    logic mclk, rst_b, link_clk, cmd_valid, cmd_write, cmd_nonvolatile;
    logic [31:0] cmd_addr;
    logic [7:0] cmd_wdata, rd_data;
    logic octal_ddr_boot_option, bank_busy, rd_valid, reserved_write_flag;
    logic wel_clear, addr_four_byte, octal_ddr, strobe_enable, cfg_ready;
    logic ecc_error_type_select;
    logic [1:0] bank_id;
    logic [4:0] fast_read_wait;
    flash_cfg_pkg::ecc_evt_s ecc_evt;
    flash_cfg_pkg::cfg_set_s active_cfg;
    int bad_count, comparisons;
    localparam logic [15:0] DFLT [11] = '{16'h00ff, 16'h011f, 16'h03ff,
        16'h05ff, 16'h06ff, 16'h07ff, 16'h0bff, 16'h02ff, 16'h12ff,
        16'h0c00, 16'h1100};
    // address, data, byte index within the working config
    localparam logic [23:0] GOOD [14] = '{24'h07fe05, 24'h07fd05,
        24'h07fc05, 24'h07ff05, 24'h03fe02, 24'h03fd02, 24'h03fc02,
        24'h05fe03, 24'h06fe04, 24'h00df00, 24'h00e700, 24'h00c700,
        24'h011e01, 24'h010101};
    localparam logic [15:0] BAD [7] = '{16'h0700, 16'h05fd, 16'h03fb,
        16'h00e6, 16'h0120, 16'h0200, 16'h06fd};
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    flash_config_status_regs dut_u (.mclk, .rst_b, .link_clk, .cmd_valid,
        .cmd_write, .cmd_nonvolatile, .cmd_addr, .cmd_wdata,
        .octal_ddr_boot_option, .ecc_evt, .bank_busy, .bank_id, .rd_data,
        .rd_valid, .reserved_write_flag, .wel_clear, .active_cfg,
        .fast_read_wait, .addr_four_byte, .octal_ddr, .strobe_enable,
        .ecc_error_type_select, .cfg_ready);
    xspi_host_model host_u (.mclk, .rd_data, .rd_valid,
        .reserved_write_flag, .wel_clear, .link_clk, .cmd_valid,
        .cmd_write, .cmd_nonvolatile, .cmd_addr, .cmd_wdata);
    task check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask : check
    task rd(input logic nv, input logic [31:0] a, input logic [7:0] e);
        host_u.xfer(1'b0, nv, a, 8'h00);
        check({host_u.got_rd, host_u.got_data}, {1'b1, e});
    endtask : rd
    task wr(input logic nv, input logic [7:0] a, input logic [7:0] d,
        input logic bad);
        host_u.xfer(1'b1, nv, {24'h0, a}, d);
        check({host_u.got_flag, host_u.got_wel}, {bad, bad});
    endtask : wr
    task rd_fca(input logic [31:0] ca);
        for (int i = 0; i < 4; i++) rd(1'b0, 32'h0d + i, ca[8*i +: 8]);
    endtask : rd_fca
    task pulse(input flash_cfg_pkg::ecc_evt_s e);
        @(negedge mclk);
        ecc_evt = e;
        @(negedge mclk);
        ecc_evt = '0;
    endtask : pulse
    task do_reset;
        rst_b = 1'b0;
        repeat (12) @(negedge mclk);
        rst_b = 1'b1;
        repeat (10) @(negedge mclk);
    endtask : do_reset
    task end_of_test;
        $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #300000;
        bad_count++;
        end_of_test();
    end
    initial begin
        {octal_ddr_boot_option, bank_busy, bank_id} = 4'h0;
        ecc_evt = '0;
        do_reset();
        check(cfg_ready, 1'b1);
        check(ecc_error_type_select, 1'b1);
        foreach (DFLT[i]) begin
            rd(1'b0, {24'h0, DFLT[i][15:8]}, DFLT[i][7:0]);
        end
        // double-bit capture first, single-bit event must not overwrite
        pulse({5'b01000, 28'h89abcde});
        pulse({5'b10000, 28'h1111111});
        rd(1'b0, 32'h0c, 8'h0c);
        wr(1'b0, 8'h0c, 8'h00, 1'b0);
        rd(1'b0, 32'h0c, 8'h0c);
        rd_fca(32'h89abcde0);
        pulse({5'b00111, 28'h0});
        repeat (14) pulse({5'b10000, 28'h2222222});
        rd(1'b0, 32'h0c, 8'hff);
        pulse({5'b10000, 28'h2222222});
        rd(1'b0, 32'h0c, 8'hff);
        wr(1'b0, 8'h0b, 8'hfb, 1'b0);
        check(ecc_error_type_select, 1'b0);
        pulse({5'b10000, 28'h0fedcba});
        pulse({5'b01000, 28'h5555555});
        rd_fca(32'h0fedcba0);
        bank_busy = 1'b1;
        for (int i = 0; i < 4; i++) begin
            bank_id = i[1:0];
            rd(1'b0, 32'h11, {6'h01, i[1:0]});
        end
        rd(1'b0, 32'ha5a5_a511, 8'h07);
        bank_busy = 1'b0;
        rd(1'b0, 32'h11, 8'h00);
        foreach (GOOD[i]) begin
            wr(1'b0, GOOD[i][23:16], GOOD[i][15:8], 1'b0);
            rd(1'b0, {24'h0, GOOD[i][23:16]}, GOOD[i][15:8]);
            check(active_cfg[8*GOOD[i][2:0] +: 8], GOOD[i][15:8]);
        end
        check({octal_ddr, strobe_enable}, 2'b10);
        check(addr_four_byte, 1'b1);
        check(fast_read_wait, 5'h01);
        wr(1'b0, 8'h01, 8'h00, 1'b0);
        check(fast_read_wait, 5'h1f);
        foreach (BAD[i]) wr(1'b0, BAD[i][15:8], BAD[i][7:0], 1'b1);
        rd(1'b0, 32'h07, 8'hff);
        rd(1'b0, 32'h03, 8'hfc);
        wr(1'b1, 8'h06, 8'hf8, 1'b0);
        rd(1'b1, 32'h06, 8'hf8);
        check(active_cfg.xip, 8'hfe);
        octal_ddr_boot_option = 1'b1;
        do_reset();
        check(active_cfg.io, 8'he7);
        check({octal_ddr, strobe_enable}, 2'b11);
        rd(1'b1, 32'h00, 8'hff);
        wr(1'b1, 8'h00, 8'hc7, 1'b1);
        rd(1'b0, 32'h06, 8'hff);
        end_of_test();
    end
endmodule : flash_config_status_regs_tb
`default_nettype wire
